// >>> rtl/pdn_pkg.sv
/*
 power-down entry control package: states, reset values and sync depth.
 assumes one 50 MHz clock and synchronous active-high reset.
*/
package pdn_pkg;
    // ==========================================================
    // states
    typedef enum logic [1:0]
    {
        MODE_RUN,
        MODE_QUASI_IDLE,
        MODE_POWER_DOWN
    } pdn_state_e;

    localparam int         WAKE_PINS_DEFAULT = 8;
    localparam int         SYNC_STAGES       = 3;
    localparam logic       SELECT_RESET      = 1'b0;
    localparam logic       TRISTATE_WAIT_ON  = 1'b0;
    localparam logic [2:0] SYNC_RESET        = 3'h0;
endpackage

// >>> rtl/pin_sync.sv
/*
 three-stage pin synchroniser with agreement filter, one per bit.
 assumes asynchronous pin inputs; the registered level changes only when stages two and three agree, and reset_level inverts it.
*/
module pin_sync
    import pdn_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // pins in, filtered levels out
    input  wire logic [WIDTH-1:0] pin,
    input  wire logic [WIDTH-1:0] reset_level,
    output logic      [WIDTH-1:0] level
);
    // ==========================================================
    // parameter check
    if (WIDTH < 1)
        $error("WIDTH must be at least 1");

    // ==========================================================
    // per-bit synchroniser
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_bit
            logic [2:0] stage_r;
            logic       level_r;
            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    stage_r <= SYNC_RESET;
                    level_r <= 1'b0;
                end
                else
                begin
                    stage_r <= {stage_r[1:0], pin[g]};
                    // stage 0 is read only by stage 1
                    if (stage_r[1] == stage_r[2])
                        level_r <= stage_r[2];
                end
            end
            assign level[g] = level_r ^ reset_level[g];
        end
    endgenerate
endmodule

// >>> rtl/power_down_entry_control.sv
/*
 power-down entry decision for the cpu's power-down instruction, including
 the quasi-idle defect of external-bus fetches.
 assumes the cpu pulses power_down_instruction for one cycle when it executes
 the instruction, and supplies bus-state qualifiers on the same clock.
*/
module power_down_entry_control
    import pdn_pkg::*;
#(
    parameter int WAKE_PINS = WAKE_PINS_DEFAULT
)
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // cpu side
    input  wire logic                 power_down_instruction,
    input  wire logic                 wake_source_select,
    input  wire logic                 next_fetch_external,
    input  wire logic                 mux_bus_active,
    input  wire logic                 mux_tristate_wait_control,
    input  wire logic                 prev_write_external,
    input  wire logic                 wake_down,
    // pins
    input  wire logic                 nmi_pin,
    input  wire logic [WAKE_PINS-1:0] wake_pin,
    input  wire logic [WAKE_PINS-1:0] wake_enable,
    input  wire logic [WAKE_PINS-1:0] wake_active_low,
    // status
    output logic                      power_down,
    output logic                      quasi_idle,
    output logic                      fetch_stall,
    output logic                      irq_block,
    output logic                      instr_ignored,
    output logic                      instr_done
);
    // ==========================================================
    // parameter check
    if (WAKE_PINS < 1 || WAKE_PINS > 16)
        $error("WAKE_PINS must be 1..16");

    // ==========================================================
    // pin synchronisers
    logic [WAKE_PINS:0] sync_level;
    pin_sync #(.WIDTH(WAKE_PINS + 1)) u_sync
    (
        .clk         (clk),
        .rst         (rst),
        .pin         ({nmi_pin, wake_pin}),
        .reset_level ({1'b0, wake_active_low}),
        .level       (sync_level)
    );

    // ==========================================================
    // entry decode
    pdn_state_e state_r;
    pdn_state_e state_nxt;
    logic       ignored_r;
    logic       done_r;

    // nmi rides the same chain so both wake sources line up in time
    wire nmi_high      = sync_level[WAKE_PINS];
    wire wake_any      = |(sync_level[WAKE_PINS-1:0] & wake_enable);
    wire block_nmi     = !wake_source_select && nmi_high;
    wire block_wake    = wake_source_select && wake_any;
    wire entry_ok      = !block_nmi && !block_wake;
    wire stall_mux     = next_fetch_external && mux_bus_active
                         && (mux_tristate_wait_control == TRISTATE_WAIT_ON);
    wire stall_write   = prev_write_external && next_fetch_external;
    // the stall outranks the pin check: the fetch dies before pins count
    wire stall_case    = stall_mux || stall_write;
    wire pd_in_run     = power_down_instruction && (state_r == MODE_RUN);

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            MODE_RUN:
            begin
                // an ignored instruction leaves state untouched
                if (pd_in_run && stall_case)
                    state_nxt = MODE_QUASI_IDLE;
                else if (pd_in_run && entry_ok)
                    state_nxt = MODE_POWER_DOWN;
            end
            MODE_QUASI_IDLE:
            begin
                // only nmi low releases the stall; the watchdog is outside
                if (!nmi_high)
                    state_nxt = MODE_POWER_DOWN;
            end
            MODE_POWER_DOWN:
            begin
                // wake detection sits outside this block
                if (wake_down)
                    state_nxt = MODE_RUN;
            end
            default:
                state_nxt = MODE_RUN;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_r   <= MODE_RUN;
            ignored_r <= 1'b0;
            done_r    <= 1'b0;
        end
        else
        begin
            state_r   <= state_nxt;
            // one-cycle pulse: the instruction retires as a no-operation
            ignored_r <= pd_in_run && !stall_case && !entry_ok;
            done_r    <= pd_in_run && !stall_case && !entry_ok;
        end
    end

    // ==========================================================
    // outputs
    assign power_down    = (state_r == MODE_POWER_DOWN);
    assign quasi_idle    = (state_r == MODE_QUASI_IDLE);
    assign fetch_stall   = quasi_idle;
    assign irq_block     = quasi_idle;
    assign instr_ignored = ignored_r;
    assign instr_done    = done_r;

    // ==========================================================
    // assertions
    // steps shared by the entry properties
    sequence s_pd_taken;
        power_down_instruction && state_r == MODE_RUN;
    endsequence

    sequence s_pd_blocked;
        s_pd_taken ##0 (!stall_case && !entry_ok);
    endsequence

    sequence s_pd_refused;
        power_down_instruction && state_r != MODE_RUN;
    endsequence

    property p_nmi_blocks;
        @(posedge clk) disable iff (rst)
        s_pd_taken ##0 (!wake_source_select && nmi_high && !stall_case)
            |=> !power_down && !quasi_idle;
    endproperty
    a_nmi_blocks: assert property (p_nmi_blocks) else $error("power-down entered with nmi high");

    property p_wake_blocks;
        @(posedge clk) disable iff (rst)
        s_pd_taken ##0 (wake_source_select && wake_any && !stall_case)
            |=> state_r == MODE_RUN;
    endproperty
    a_wake_blocks: assert property (p_wake_blocks) else $error("power-down entered with wake pin active");

    property p_entry;
        @(posedge clk) disable iff (rst)
        s_pd_taken ##0 (entry_ok && !stall_case)
            |=> power_down;
    endproperty
    a_entry: assert property (p_entry) else $error("power-down not entered");

    property p_mux_stall;
        @(posedge clk) disable iff (rst)
        s_pd_taken ##0 stall_mux
            |=> quasi_idle && fetch_stall;
    endproperty
    a_mux_stall: assert property (p_mux_stall) else $error("mux stall not taken");

    property p_write_stall;
        @(posedge clk) disable iff (rst)
        s_pd_taken ##0 stall_write
            |=> quasi_idle;
    endproperty
    a_write_stall: assert property (p_write_stall) else $error("write stall not taken");

    property p_irq_held;
        @(posedge clk) disable iff (rst)
        (quasi_idle && nmi_high)
            |=> quasi_idle && irq_block;
    endproperty
    a_irq_held: assert property (p_irq_held) else $error("quasi-idle not held with nmi high");

    property p_nmi_release;
        @(posedge clk) disable iff (rst)
        (quasi_idle && !nmi_high)
            |=> power_down;
    endproperty
    a_nmi_release: assert property (p_nmi_release) else $error("nmi low did not power down");

    property p_ignored_nop;
        @(posedge clk) disable iff (rst)
        s_pd_blocked
            |=> instr_ignored && instr_done && state_r == $past(state_r);
    endproperty
    a_ignored_nop: assert property (p_ignored_nop) else $error("ignored instruction changed state");

    property p_refused;
        @(posedge clk) disable iff (rst)
        s_pd_refused
            |=> !instr_ignored && !instr_done;
    endproperty
    a_refused: assert property (p_refused) else $error("instruction outside run was reported");

    property p_pd_hold;
        @(posedge clk) disable iff (rst)
        (power_down && !wake_down)
            |=> power_down;
    endproperty
    a_pd_hold: assert property (p_pd_hold) else $error("power-down left without wake");
endmodule

// >>> tb/pdn_partner.sv
/*
 far-side model: the nmi source and the wake pins.
 assumes the bench commands levels; pins follow one edge later, on the same clock edge that the design samples.
*/
module pdn_partner
#(
    parameter int WIDTH = 8
)
(
    // clock
    input  wire logic             clk,
    // commanded levels
    input  wire logic             nmi_cmd,
    input  wire logic [WIDTH-1:0] wake_cmd,
    // pins
    output logic                  nmi_pin,
    output logic      [WIDTH-1:0] wake_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // pin drivers
    // start high so the nmi pin blocks entry until told otherwise
    initial
    begin
        nmi_pin = 1'b1;
        wake_pin = '0;
        forever
        begin
            @(posedge clk);
            nmi_pin <= nmi_cmd;
            wake_pin <= wake_cmd;
        end
    end
endmodule

// >>> tb/tb.sv
/*
 self-checking bench for the power-down entry decision, random and corner trials.
 assumes the partner model drives the pins and the cpu side is driven here.
*/
module tb import pdn_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int N = WAKE_PINS_DEFAULT;
    logic clk = 1'b0, rst = 1'b1, instr = 1'b0, sel = 1'b0, nmi_cmd = 1'b1, wake_down = 1'b0;
    logic [3:0] bus = 4'h0;
    logic [N-1:0] wake_cmd = '0, wen = '0, wal = '0, wake_pin;
    logic nmi_pin, pd, qi, fs, ib, ign, dn;
    int bad_count = 0, tests_run = 0;
    pdn_partner #(.WIDTH(N)) far (.clk(clk), .nmi_cmd(nmi_cmd), .wake_cmd(wake_cmd),
        .nmi_pin(nmi_pin), .wake_pin(wake_pin));
    power_down_entry_control #(.WAKE_PINS(N)) DUT (.clk(clk), .rst(rst), .power_down_instruction(instr),
        .wake_source_select(sel), .next_fetch_external(bus[3]), .mux_bus_active(bus[2]),
        .mux_tristate_wait_control(bus[1]), .prev_write_external(bus[0]), .wake_down(wake_down),
        .nmi_pin(nmi_pin), .wake_pin(wake_pin), .wake_enable(wen), .wake_active_low(wal),
        .power_down(pd), .quasi_idle(qi), .fetch_stall(fs), .irq_block(ib), .instr_ignored(ign),
        .instr_done(dn));
    // ==========================================================
    // helpers
    initial forever #10 clk = ~clk;
    // result {power_down, quasi_idle, ignored}; the stall beats the pin check
    function automatic logic [2:0] outcome(logic s, logic n, logic [N-1:0] w, e, a, logic [3:0] b);
        if (b[3] && ((b[2] && !b[1]) || b[0]))
            return 3'h2;
        if (s ? |(e & (w ^ a)) : n)
            return 3'h1;
        return 3'h4;
    endfunction
    task automatic check(logic [2:0] got, logic [2:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic pulse_instr;
        @(posedge clk);
        instr <= 1'b1;
        @(posedge clk);
        instr <= 1'b0;
        #1;
    endtask
    // look after the edge, once the outputs have settled
    task automatic step;
        @(posedge clk);
        #1;
    endtask
    // stall, refused instruction, then a watchdog-style reset while still in quasi-idle
    task automatic stall_reset;
        @(posedge clk);
        sel <= 1'b0;
        nmi_cmd <= 1'b1;
        bus <= 4'hc;
        repeat (6) @(posedge clk);
        pulse_instr();
        check({pd, qi, ign}, 3'h2);
        pulse_instr();
        check({pd, qi, ign}, 3'h2);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        check({pd, qi, ign}, 3'h0);
        check({dn, fs, ib}, 3'h0);
        $display("stall reset test ended");
    endtask
    task automatic trial(logic s, logic n, logic [N-1:0] w, e, a, logic [3:0] b);
        logic [2:0] exp;
        int         k;
        exp = outcome(s, n, w, e, a, b);
        @(posedge clk);
        sel <= s;
        nmi_cmd <= n;
        wake_cmd <= w;
        wen <= e;
        wal <= a;
        bus <= b;
        // partner edge plus four sync edges (three stages and the filter) before the level counts
        repeat (6) @(posedge clk);
        pulse_instr();
        check({pd, qi, ign}, exp);
        check({dn, fs, ib}, {exp[0], exp[1], exp[1]});
        if (exp == 3'h1)
        begin
            @(posedge clk);
            #1;
            check({pd, qi, ign}, 3'h0);
        end
        if (exp == 3'h2)
        begin
            @(posedge clk);
            nmi_cmd <= 1'b0;
            for (k = 0; k < 8 && pd !== 1'b1; k++)
                step();
            #1;
            check({pd, qi, fs}, 3'h4);
        end
        if (pd === 1'b1)
        begin
            // a second instruction while powered down is refused silently
            pulse_instr();
            check({pd, qi, ign}, 3'h4);
            @(posedge clk);
            wake_down <= 1'b1;
            @(posedge clk);
            wake_down <= 1'b0;
            for (k = 0; k < 4 && pd !== 1'b0; k++)
                step();
            #1;
            check({pd, qi, ign}, 3'h0);
        end
        $display("trial %0d ended, outcome %h", tests_run, exp);
    endtask
    // ==========================================================
    // sequence
    initial
    begin
        void'($urandom(32'hc3e1));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        trial(1'b0, 1'b1, '0, '0, '0, 4'h0);
        trial(1'b0, 1'b0, '1, '0, '0, 4'h0);
        trial(1'b1, 1'b1, 8'h80, 8'h80, 8'h00, 4'h0);
        trial(1'b1, 1'b1, 8'h00, 8'h01, 8'h01, 4'h0);
        trial(1'b1, 1'b1, 8'h7f, 8'h80, 8'h00, 4'h0);
        trial(1'b0, 1'b1, '0, '0, '0, 4'hc);
        trial(1'b1, 1'b0, '1, '1, '0, 4'h9);
        trial(1'b0, 1'b0, '0, '0, '0, 4'h6);
        trial(1'b0, 1'b0, '0, '0, '0, 4'h8);
        stall_reset();
        repeat (40)
            trial(1'($urandom), 1'($urandom), N'($urandom), N'($urandom), N'($urandom), 4'($urandom));
        end_of_test();
    end
    initial
    begin
        #200us;
        bad_count++;
        end_of_test();
    end
endmodule
